/* src/usbpf_bridge.v */
// Contract
// - Async bit-bang turns data lines into GPIO
// - Async bit-bang paces host bytes to pins
// - Sync bit-bang samples pins per written byte
// - Receive flush timeout, default 16, 2..255 ms
// - Suspend with wake enabled makes flag input
// - Flag held low 20 ms requests resume
// - Fixed unique ID, readable over host only
// - Host bytes fill 128-byte receive buffer
// - Write strobe fills 256-byte transmit buffer
// - Controller moves bytes between buffers, pins
// - Everything runs from one reference clock
// - Derived clock paces bit-bang timer
// - Recovered host data enters serial engine
// - Serial engine generates CRC5 and CRC16
// - Host commands set timeout and mode
// - Host may rewrite user data area
// - Reset input resets all internal logic; the buffer storage in usbpf_mem has no reset
// - Read falling edge fetches, drives byte
// - Write falling edge captures pin byte
// - Space flag low only when buffer accepts
// - Avail flag low only with data ready
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "usbpf_defines.vh"

module usbpf_bridge #(
  parameter [31:0] CHIP_ID = 32'h5A5A1234,
  parameter MS_CYCLES = `USBPF_MS_CYCLES
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire rd_strobe_n,
  input wire wr_strobe,
  input wire [7:0] parallel_data_pins_in,
  output reg [7:0] parallel_data_pins_out,
  output reg [7:0] parallel_data_pins_oe,
  input wire rx_avail_n_in,
  output reg rx_avail_n,
  output reg rx_avail_oe,
  output reg send_space_n,
  output reg send_space_oe,
  output reg resume_req
);

  // CHIP_ID default is arbitrary

  function [15:0] crc16_byte;
    input [15:0] c;
    input [7:0] b;
    integer i;
    reg [15:0] t;
    begin
      t = c;
      for (i = 0; i < 8; i = i + 1) begin
        if (t[0] ^ b[i]) begin
          t = (t >> 1) ^ `USBPF_CRC16_POLY;
        end else begin
          t = t >> 1;
        end
      end
      crc16_byte = t;
    end
  endfunction

  function [4:0] crc5_token;
    input [10:0] d;
    integer i;
    reg [4:0] t;
    begin
      t = `USBPF_CRC5_INIT;
      for (i = 0; i < 11; i = i + 1) begin
        if (t[0] ^ d[i]) begin
          t = (t >> 1) ^ `USBPF_CRC5_POLY;
        end else begin
          t = t >> 1;
        end
      end
      crc5_token = ~t;
    end
  endfunction

  reg [3:0] ctrl;
  reg [7:0] timeout;
  reg [15:0] divisor;
  reg [7:0] dir;
  reg [31:0] user;
  reg [15:0] crc16;
  reg [4:0] crc5;
  reg resume_sticky;
  reg rd_s1, rd_s2, rd_s3;
  reg wr_s1, wr_s2, wr_s3;
  reg [7:0] d_s1, d_s2;
  reg w_s1, w_s2;
  reg [6:0] rx_wptr, rx_rptr;
  reg [7:0] rx_cnt, rx_cnt_d;
  reg rx_pop_d;
  reg [7:0] tx_wptr, tx_rptr;
  reg [8:0] tx_cnt, tx_cnt_d;
  reg tx_pop_d;
  reg rx_release;
  reg rd_drive;
  reg [15:0] pace_cnt;
  reg [31:0] ms_cnt;
  reg [7:0] to_cnt;
  reg [4:0] wake_cnt;
  reg tx_rd_valid;

  wire [7:0] rx_dout;
  wire [7:0] tx_dout;
  wire [1:0] mode = ctrl[`USBPF_MODE_MSB:`USBPF_MODE_LSB];
  wire suspend = ctrl[`USBPF_SUSPEND_BIT];
  wire wake_en = ctrl[`USBPF_WAKE_EN_BIT];
  wire fifo_mode = (mode == `USBPF_MODE_FIFO);
  wire bb_mode = (mode == `USBPF_MODE_ASYNC) || (mode == `USBPF_MODE_SYNC);
  wire setup = psel && !penable;
  wire access = psel && penable && pready;
  wire wr_acc = access && pwrite;
  wire rd_fall = rd_s3 && !rd_s2;
  wire wr_fall = wr_s3 && !wr_s2;
  wire ms_tick = (ms_cnt == 32'h00000000);
  wire pace_tick = bb_mode && (pace_cnt == 16'h0000);
  // Registered read port: head byte valid two cycles after any pop
  wire rx_ready = (rx_cnt != 8'h00) && (rx_cnt_d != 8'h00) && !rx_pop_d;
  wire tx_ready = (tx_cnt != 9'h000) && (tx_cnt_d != 9'h000) && !tx_pop_d;
  wire rx_full = (rx_cnt == `USBPF_RX_DEPTH);
  wire tx_full = (tx_cnt == `USBPF_TX_DEPTH);
  wire rx_push = wr_acc && (paddr == `USBPF_A_RXDATA) && !rx_full;
  wire fifo_rd = fifo_mode && rd_fall && !rx_avail_n && rx_ready;
  wire bb_go = pace_tick && rx_ready && !(mode == `USBPF_MODE_SYNC && tx_full);
  wire rx_pop = fifo_rd || bb_go;
  wire fifo_wr = fifo_mode && wr_fall && !tx_full;
  // Async samples on every tick; sync only with each byte driven out
  wire bb_sample = ((mode == `USBPF_MODE_ASYNC) && pace_tick) ||
                   ((mode == `USBPF_MODE_SYNC) && bb_go);
  wire tx_push = fifo_wr || (bb_sample && !tx_full);
  wire tx_pop = access && !pwrite && (paddr == `USBPF_A_TXDATA) && tx_rd_valid;
  wire wake_fire = (wake_cnt == `USBPF_WAKE_TICKS - 5'h01) && ms_tick &&
                   suspend && wake_en && !w_s2;
  wire [7:0] tx_byte = fifo_wr ? d_s2 : d_s2;
  wire [8:0] next_tx_cnt = tx_cnt + {8'h00, tx_push} - {8'h00, tx_pop};
  wire [7:0] timeout_lim = (timeout < `USBPF_TIMEOUT_MIN) ? `USBPF_TIMEOUT_MIN : timeout;

  usbpf_mem #(.AW(7)) u_rx_mem (
    .pclk(pclk),
    .wr_en(rx_push),
    .wr_addr(rx_wptr),
    .wr_data(pwdata[7:0]),
    .rd_addr(rx_rptr),
    .rd_data(rx_dout)
  );

  usbpf_mem #(.AW(8)) u_tx_mem (
    .pclk(pclk),
    .wr_en(tx_push),
    .wr_addr(tx_wptr),
    .wr_data(tx_byte),
    .rd_addr(tx_rptr),
    .rd_data(tx_dout)
  );

  // Strobes and pins from outside pass two flops first
  // Strobes shorter than a clock period may be missed at this rate
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_s1 <= 1'b1;
      rd_s2 <= 1'b1;
      rd_s3 <= 1'b1;
      wr_s1 <= 1'b0;
      wr_s2 <= 1'b0;
      wr_s3 <= 1'b0;
      d_s1 <= 8'h00;
      d_s2 <= 8'h00;
      w_s1 <= 1'b1;
      w_s2 <= 1'b1;
    end else begin
      rd_s1 <= rd_strobe_n;
      rd_s2 <= rd_s1;
      rd_s3 <= rd_s2;
      wr_s1 <= wr_strobe;
      wr_s2 <= wr_s1;
      wr_s3 <= wr_s2;
      d_s1 <= parallel_data_pins_in;
      d_s2 <= d_s1;
      w_s1 <= rx_avail_n_in;
      w_s2 <= w_s1;
    end
  end

  // Buffers, one clock for all paths
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_wptr <= 7'h00;
      rx_rptr <= 7'h00;
      rx_cnt <= 8'h00;
      rx_cnt_d <= 8'h00;
      rx_pop_d <= 1'b0;
      tx_wptr <= 8'h00;
      tx_rptr <= 8'h00;
      tx_cnt <= 9'h000;
      tx_cnt_d <= 9'h000;
      tx_pop_d <= 1'b0;
    end else begin
      if (rx_push) begin
        rx_wptr <= rx_wptr + 7'h01;
      end
      if (rx_pop) begin
        rx_rptr <= rx_rptr + 7'h01;
      end
      rx_cnt <= rx_cnt + {7'h00, rx_push} - {7'h00, rx_pop};
      rx_cnt_d <= rx_cnt;
      rx_pop_d <= rx_pop;
      if (tx_push) begin
        tx_wptr <= tx_wptr + 8'h01;
      end
      if (tx_pop) begin
        tx_rptr <= tx_rptr + 8'h01;
      end
      tx_cnt <= next_tx_cnt;
      tx_cnt_d <= tx_cnt;
      tx_pop_d <= tx_pop;
    end
  end

  // Timers: millisecond prescaler, flush timeout, wake hold, pacer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt <= 32'h00000000;
      to_cnt <= 8'h00;
      rx_release <= 1'b0;
      wake_cnt <= 5'h00;
      pace_cnt <= 16'h0000;
    end else begin
      ms_cnt <= ms_tick ? MS_CYCLES - 1 : ms_cnt - 32'h00000001;
      if (rx_push) begin
        to_cnt <= 8'h00;
      end else if (ms_tick && to_cnt != 8'hFF) begin
        to_cnt <= to_cnt + 8'h01;
      end
      // Residue released to the reader after the timeout or when full
      if (rx_cnt == 8'h00) begin
        rx_release <= 1'b0;
      end else if (to_cnt >= timeout_lim || rx_full) begin
        rx_release <= 1'b1;
      end
      if (!(suspend && wake_en) || w_s2) begin
        wake_cnt <= 5'h00;
      end else if (ms_tick && wake_cnt != `USBPF_WAKE_TICKS) begin
        wake_cnt <= wake_cnt + 5'h01;
      end
      if (!bb_mode || pace_tick) begin
        pace_cnt <= (divisor == 16'h0000) ? 16'h0000 : divisor - 16'h0001;
      end else begin
        pace_cnt <= pace_cnt - 16'h0001;
      end
    end
  end

  // Pins and flags
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      parallel_data_pins_out <= 8'h00;
      parallel_data_pins_oe <= 8'h00;
      rd_drive <= 1'b0;
      rx_avail_n <= 1'b1;
      rx_avail_oe <= 1'b0;
      send_space_n <= 1'b1;
      send_space_oe <= 1'b0;
      resume_req <= 1'b0;
    end else begin
      if (fifo_rd) begin
        parallel_data_pins_out <= rx_dout;
      end else if (bb_go) begin
        parallel_data_pins_out <= rx_dout;
      end
      if (fifo_rd) begin
        rd_drive <= 1'b1;
      end else if (rd_s2 || !fifo_mode) begin
        rd_drive <= 1'b0;
      end
      if (bb_mode) begin
        parallel_data_pins_oe <= dir;
      end else begin
        parallel_data_pins_oe <= (fifo_rd || (rd_drive && !rd_s2)) ? 8'hFF : 8'h00;
      end
      // Held high through a read cycle and one cycle after it
      rx_avail_n <= !(fifo_mode && rx_release && rx_ready && !fifo_rd &&
                      !rd_drive && rd_s2);
      rx_avail_oe <= !(suspend && wake_en);
      send_space_n <= !fifo_mode || (next_tx_cnt == `USBPF_TX_DEPTH) || wr_fall;
      send_space_oe <= 1'b1;
      resume_req <= wake_fire;
    end
  end

  // APB slave: one wait-free access phase, outputs registered
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `USBPF_CTRL_RESET;
      timeout <= `USBPF_TIMEOUT_RESET;
      divisor <= `USBPF_DIVISOR_RESET;
      dir <= 8'h00;
      user <= 32'h00000000;
      crc16 <= `USBPF_CRC16_INIT;
      crc5 <= 5'h00;
      resume_sticky <= 1'b0;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      tx_rd_valid <= 1'b0;
    end else begin
      pready <= setup;
      if (wr_acc) begin
        case (paddr)
          `USBPF_A_CTRL: ctrl <= pwdata[3:0];
          `USBPF_A_TIMEOUT: timeout <= (pwdata[7:0] < `USBPF_TIMEOUT_MIN) ?
                                       `USBPF_TIMEOUT_MIN : pwdata[7:0];
          `USBPF_A_DIVISOR: divisor <= pwdata[15:0];
          `USBPF_A_DIR: dir <= pwdata[7:0];
          `USBPF_A_USER: user <= pwdata;
          `USBPF_A_CRC16: crc16 <= pwdata[`USBPF_CRC_INIT_BIT] ? `USBPF_CRC16_INIT :
                                   crc16_byte(crc16, pwdata[7:0]);
          `USBPF_A_CRC5: crc5 <= crc5_token(pwdata[10:0]);
          default: crc5 <= crc5;
        endcase
      end
      // Set wins over a clear in the same cycle
      if (wake_fire) begin
        resume_sticky <= 1'b1;
      end else if (wr_acc && paddr == `USBPF_A_STATUS && pwdata[`USBPF_ST_RESUME_BIT]) begin
        resume_sticky <= 1'b0;
      end
      if (setup) begin
        pslverr <= 1'b0;
        tx_rd_valid <= 1'b0;
        case (paddr)
          `USBPF_A_CTRL: prdata <= {28'h0000000, ctrl};
          `USBPF_A_TIMEOUT: prdata <= {24'h000000, timeout};
          `USBPF_A_DIVISOR: prdata <= {16'h0000, divisor};
          `USBPF_A_DIR: prdata <= {24'h000000, dir};
          `USBPF_A_STATUS: prdata <= {7'h00, tx_cnt, rx_cnt, 5'h00, resume_sticky,
                                      !send_space_n, !rx_avail_n};
          `USBPF_A_RXDATA: prdata <= 32'h00000000;
          `USBPF_A_TXDATA: begin
            prdata <= {23'h000000, tx_ready, tx_ready ? tx_dout : 8'h00};
            tx_rd_valid <= tx_ready && !pwrite;
          end
          `USBPF_A_CHIPID: prdata <= CHIP_ID;
          `USBPF_A_USER: prdata <= user;
          `USBPF_A_CRC16: prdata <= {16'h0000, ~crc16};
          `USBPF_A_CRC5: prdata <= {27'h0000000, crc5};
          default: begin
            prdata <= 32'h00000000;
            pslverr <= 1'b1;
          end
        endcase
        if (pwrite) begin
          prdata <= 32'h00000000;
          if (paddr == `USBPF_A_CHIPID || paddr == `USBPF_A_TXDATA ||
              (paddr == `USBPF_A_RXDATA && rx_full)) begin
            pslverr <= 1'b1;
          end
        end
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

endmodule // usbpf_bridge

`default_nettype wire

/* src/usbpf_defines.vh */
`ifndef USBPF_DEFINES_VH
`define USBPF_DEFINES_VH

`define USBPF_A_CTRL 8'h00
`define USBPF_A_TIMEOUT 8'h04
`define USBPF_A_DIVISOR 8'h08
`define USBPF_A_DIR 8'h0C
`define USBPF_A_STATUS 8'h10
`define USBPF_A_RXDATA 8'h14
`define USBPF_A_TXDATA 8'h18
`define USBPF_A_CHIPID 8'h1C
`define USBPF_A_USER 8'h20
`define USBPF_A_CRC16 8'h24
`define USBPF_A_CRC5 8'h28

`define USBPF_MODE_LSB 0
`define USBPF_MODE_MSB 1
`define USBPF_SUSPEND_BIT 2
`define USBPF_WAKE_EN_BIT 3
`define USBPF_CRC_INIT_BIT 31
`define USBPF_ST_RESUME_BIT 2

`define USBPF_MODE_FIFO 2'h0
`define USBPF_MODE_ASYNC 2'h1
`define USBPF_MODE_SYNC 2'h2

`define USBPF_CTRL_RESET 4'h8
`define USBPF_TIMEOUT_RESET 8'h10
`define USBPF_TIMEOUT_MIN 8'h02
`define USBPF_DIVISOR_RESET 16'h000A
`define USBPF_CRC16_INIT 16'hFFFF
`define USBPF_CRC16_POLY 16'hA001
`define USBPF_CRC5_INIT 5'h1F
`define USBPF_CRC5_POLY 5'h14

`define USBPF_RX_DEPTH 8'h80
`define USBPF_TX_DEPTH 9'h100

`define USBPF_CLK_NS 100
`define USBPF_MS_NS 1000000
`define USBPF_MS_CYCLES (`USBPF_MS_NS / `USBPF_CLK_NS)
`define USBPF_WAKE_MS 20
`define USBPF_WAKE_TICKS 5'h15

`endif

/* src/usbpf_mem.v */
`timescale 1ns/100ps
`default_nettype none

module usbpf_mem #(
  parameter AW = 7
) (
  input wire pclk,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [7:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output reg [7:0] rd_data
);

  reg [7:0] mem [0:(1<<AW)-1];

  // No reset: storage only, read data registered every cycle
  always @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule // usbpf_mem

`default_nettype wire

/* tb/usbpf_bridge_test.sv */
`timescale 1ns/100ps
`default_nettype none
`include "usbpf_defines.vh"
module usbpf_bridge_test;
  localparam int MS = 10;
  localparam logic [31:0] ID = 32'h13572468; // Arbitrary value
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_n, wr, av_in, av, av_oe;
  logic sp, sp_oe, resume, re, ok;
  logic [7:0] paddr, pin_in, pin_out, pin_oe, b;
  logic [31:0] pwdata, prdata, rq, rv;
  logic [7:0] exp_q[$];
  int n_errors, checks_done, n_resume, i, n;
  usbpf_bridge #(.CHIP_ID(ID), .MS_CYCLES(MS)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rd_strobe_n(rd_n),
    .wr_strobe(wr), .parallel_data_pins_in(pin_in), .parallel_data_pins_out(pin_out),
    .parallel_data_pins_oe(pin_oe), .rx_avail_n_in(av_in), .rx_avail_n(av),
    .rx_avail_oe(av_oe), .send_space_n(sp), .send_space_oe(sp_oe), .resume_req(resume));
  usbpf_far_end far (.pclk(pclk), .pins_out(pin_out), .pins_oe(pin_oe), .rx_avail_n(av),
    .rx_avail_oe(av_oe), .send_space_n(sp), .rd_strobe_n(rd_n), .wr_strobe(wr),
    .pins_in(pin_in), .rx_avail_n_in(av_in));
  always #50 pclk = ~pclk;
  always @(posedge pclk) n_resume <= n_resume + int'(resume === 1'b1);
  function automatic logic [31:0] tx_word(input logic [7:0] d);
    return {23'h0, 1'b1, d};
  endfunction
  function automatic logic [15:0] crc16_ref(input logic [7:0] d);
    logic [15:0] c;
    c = `USBPF_CRC16_INIT;
    for (int k = 0; k < 8; k++) c = (c >> 1) ^ ((c[0] ^ d[k]) ? `USBPF_CRC16_POLY : 16'h0000);
    return ~c;
  endfunction
  function automatic logic [4:0] crc5_ref(input logic [10:0] d);
    logic [4:0] c;
    c = `USBPF_CRC5_INIT;
    for (int k = 0; k < 11; k++) c = (c >> 1) ^ ((c[0] ^ d[k]) ? `USBPF_CRC5_POLY : 5'h00);
    return ~c;
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge pclk);
      k++;
    end
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic complete_run;
    $display("checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #4000000;
    n_errors++;
    complete_run();
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, n_resume} = '0;
    void'($urandom(32'hAB80));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, `USBPF_A_CTRL, 0); chk("ctrl", 32'h8, rq);
    apb(0, `USBPF_A_TIMEOUT, 0); chk("timeout", 32'h10, rq);
    apb(0, `USBPF_A_DIVISOR, 0); chk("divisor", 32'hA, rq);
    apb(1, `USBPF_A_CHIPID, ~ID); chk("id write err", 32'h1, {31'h0, re});
    apb(0, `USBPF_A_CHIPID, 0); chk("id", ID, rq);
    apb(0, 8'h3C, 0); chk("unmapped err", 32'h1, {31'h0, re});
    rv = $urandom;
    apb(1, `USBPF_A_USER, rv);
    apb(0, `USBPF_A_USER, 0); chk("user", rv, rq);
    b = 8'($urandom);
    apb(1, `USBPF_A_CRC16, 32'h80000000);
    apb(1, `USBPF_A_CRC16, {24'h0, b});
    apb(0, `USBPF_A_CRC16, 0); chk("crc16", {16'h0, crc16_ref(b)}, rq);
    rv = $urandom;
    apb(1, `USBPF_A_CRC5, rv);
    apb(0, `USBPF_A_CRC5, 0); chk("crc5", {27'h0, crc5_ref(rv[10:0])}, rq);
    apb(1, `USBPF_A_TIMEOUT, 32'h1);
    apb(0, `USBPF_A_TIMEOUT, 0); chk("timeout min", 32'h2, rq);
    $display("register test done");
    b = 8'($urandom);
    apb(1, `USBPF_A_RXDATA, {24'h0, b});
    for (n = 0; n < 60 && av !== 1'b0; n++) @(posedge pclk);
    chk("flush wait ok", 32'h1, {31'h0, n > 8 && n < 40});
    far.read_byte(rq[7:0], ok); chk("flushed byte", b, rq[7:0]);
    for (i = 0; i < 129; i++) begin
      exp_q.push_back(8'($urandom));
      apb(1, `USBPF_A_RXDATA, {24'h0, exp_q[i]});
      if (i == 0) chk("early flag", 32'h1, {31'h0, av});
    end
    chk("rx full err", 32'h1, {31'h0, re});
    for (i = 0; i < 128; i++) begin
      far.read_byte(b, ok); chk("rx byte", {1'b1, exp_q[i]}, {ok, b});
    end
    repeat (4) @(posedge pclk); chk("rx empty flag", 32'h1, {31'h0, av});
    $display("receive test done");
    exp_q = {};
    for (i = 0; i < 256; i++) begin
      exp_q.push_back(8'($urandom));
      far.write_byte(exp_q[i], ok); chk("space wait", 32'h1, {31'h0, ok});
    end
    repeat (4) @(posedge pclk); chk("full flag", 32'h1, {31'h0, sp});
    apb(0, `USBPF_A_STATUS, 0); chk("tx count", 32'h100, {23'h0, rq[24:16]});
    for (i = 0; i < 257; i++) begin
      apb(0, `USBPF_A_TXDATA, 0); chk("tx word", i < 256 ? tx_word(exp_q[i]) : 0, rq);
    end
    $display("transmit test done");
    apb(1, `USBPF_A_DIR, 32'hFF);
    apb(1, `USBPF_A_DIVISOR, 32'h3);
    apb(1, `USBPF_A_CTRL, `USBPF_MODE_ASYNC);
    for (i = 0; i < 3; i++) begin
      b = 8'($urandom);
      apb(1, `USBPF_A_RXDATA, {24'h0, b});
      for (n = 0; n < 60 && (pin_out !== b || pin_oe !== 8'hFF); n++) @(posedge pclk);
      chk("paced byte seen", 32'h1, {31'h0, n < 60});
    end
    apb(1, `USBPF_A_DIR, 32'h0F);
    apb(1, `USBPF_A_CTRL, `USBPF_MODE_SYNC);
    for (n = 0; n < 300 && (n == 0 || rq[8] === 1'b1); n++) apb(0, `USBPF_A_TXDATA, 0);
    b = 8'($urandom);
    apb(1, `USBPF_A_RXDATA, {24'h0, b});
    apb(1, `USBPF_A_RXDATA, 32'h0);
    repeat (40) @(posedge pclk);
    apb(0, `USBPF_A_TXDATA, 0); chk("sync first", 32'h1, {31'h0, rq[8]});
    apb(0, `USBPF_A_TXDATA, 0); chk("sync second", tx_word({4'hF, b[3:0]}), rq);
    apb(0, `USBPF_A_TXDATA, 0); chk("sync count", 32'h0, rq);
    $display("bit-bang test done");
    apb(1, `USBPF_A_CTRL, 32'hC);
    @(posedge pclk);
    chk("flag released", 32'h0, {31'h0, av_oe});
    far.wake(19 * MS); chk("short wake", 32'h0, n_resume);
    far.wake(23 * MS); chk("long wake", 32'h1, n_resume);
    apb(0, `USBPF_A_STATUS, 0); chk("resume bit", 32'h1, {31'h0, rq[2]});
    $display("wake test done");
    complete_run();
  end
endmodule // usbpf_bridge_test
bind usbpf_bridge usbpf_props #(.MS_CYCLES(MS_CYCLES)) u_props (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .rd_strobe_n(rd_strobe_n),
  .wr_strobe(wr_strobe), .parallel_data_pins_oe(parallel_data_pins_oe),
  .rx_avail_n_in(rx_avail_n_in), .rx_avail_n(rx_avail_n), .rx_avail_oe(rx_avail_oe),
  .send_space_n(send_space_n), .send_space_oe(send_space_oe), .resume_req(resume_req));
`default_nettype wire

/* tb/usbpf_far_end.sv */
`timescale 1ns/100ps
`default_nettype none
module usbpf_far_end (
  input wire logic pclk,
  input wire logic [7:0] pins_out,
  input wire logic [7:0] pins_oe,
  input wire logic rx_avail_n,
  input wire logic rx_avail_oe,
  input wire logic send_space_n,
  output logic rd_strobe_n,
  output logic wr_strobe,
  output logic [7:0] pins_in,
  output logic rx_avail_n_in
);
  logic [7:0] drv;
  logic drv_en;
  logic wake_low;
  initial begin
    rd_strobe_n = 1'b1;
    wr_strobe = 1'b0;
    drv = 8'h00;
    drv_en = 1'b0;
    wake_low = 1'b0;
  end
  // Released lines float to the pull-up level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pins_in[i] = pins_oe[i] ? pins_out[i] : (drv_en ? drv[i] : 1'b1);
    end
    rx_avail_n_in = rx_avail_oe ? rx_avail_n : !wake_low;
  end
  task automatic read_byte(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    while (rx_avail_n !== 1'b0 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    ok = n < 400;
    rd_strobe_n <= 1'b0;
    repeat (6) @(posedge pclk);
    b = pins_in;
    rd_strobe_n <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask
  task automatic write_byte(input logic [7:0] b, output logic ok);
    int n;
    n = 0;
    while (send_space_n !== 1'b0 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    ok = n < 400;
    drv <= b;
    drv_en <= 1'b1;
    wr_strobe <= 1'b1;
    repeat (4) @(posedge pclk);
    wr_strobe <= 1'b0;
    repeat (5) @(posedge pclk);
    drv_en <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wake(input int cycles);
    wake_low <= 1'b1;
    repeat (cycles) @(posedge pclk);
    wake_low <= 1'b0;
    @(posedge pclk);
  endtask
endmodule // usbpf_far_end
`default_nettype wire

/* tb/usbpf_props.sv */
`timescale 1ns/100ps
`default_nettype none
module usbpf_props #(
  parameter int MS_CYCLES = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rd_strobe_n,
  input wire logic wr_strobe,
  input wire logic [7:0] parallel_data_pins_oe,
  input wire logic rx_avail_n_in,
  input wire logic rx_avail_n,
  input wire logic rx_avail_oe,
  input wire logic send_space_n,
  input wire logic send_space_oe,
  input wire logic resume_req
);
  logic [3:0] ctrl;
  logic [31:0] low_cnt;
  wire fifo = ctrl[1:0] == 2'h0;
  // Mode mirrored from bus writes, since the checker cannot see the register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= 4'h8;
      low_cnt <= 32'h0;
    end else begin
      if (psel && penable && pready && pwrite && paddr == 8'h00) begin
        ctrl <= pwdata[3:0];
      end
      low_cnt <= rx_avail_n_in ? 32'h0 : low_cnt + 32'h1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  sequence s_fetch;
    fifo && $rose(parallel_data_pins_oe == 8'hFF);
  endsequence
  property p_ready_next;
    s_setup |=> s_access;
  endproperty
  a_ready_next: assert property (p_ready_next) else $error("no answer after setup");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_fetch_after_rd;
    s_fetch |-> !$past(rd_strobe_n) && !$past(rd_strobe_n, 2);
  endproperty
  a_fetch_after_rd: assert property (p_fetch_after_rd) else $error("drive without read");
  property p_flag_on_fetch;
    s_fetch |-> rx_avail_n;
  endproperty
  a_flag_on_fetch: assert property (p_flag_on_fetch) else $error("flag low at fetch");
  property p_drive_hold;
    fifo && parallel_data_pins_oe == 8'hFF && !rd_strobe_n |=> parallel_data_pins_oe == 8'hFF;
  endproperty
  a_drive_hold: assert property (p_drive_hold) else $error("data dropped early");
  property p_drive_release;
    fifo && parallel_data_pins_oe == 8'hFF && $rose(rd_strobe_n) |-> ##[1:4]
      parallel_data_pins_oe == 8'h00;
  endproperty
  a_drive_release: assert property (p_drive_release) else $error("data not released");
  property p_space_after_wr;
    fifo && $fell(wr_strobe) && !send_space_n |-> ##[1:5] send_space_n;
  endproperty
  a_space_after_wr: assert property (p_space_after_wr) else $error("space flag stuck");
  property p_wake_input;
    ctrl[3:2] == 2'b11 && $past(ctrl[3:2]) == 2'b11 |-> !rx_avail_oe;
  endproperty
  a_wake_input: assert property (p_wake_input) else $error("flag still driven");
  property p_wake_time;
    resume_req |-> low_cnt >= 20 * MS_CYCLES ##1 !resume_req;
  endproperty
  a_wake_time: assert property (p_wake_time) else $error("resume too early");
  property p_flags_driven;
    $past(presetn) |-> send_space_oe;
  endproperty
  a_flags_driven: assert property (p_flags_driven) else $error("space flag floats");
endmodule // usbpf_props
`default_nettype wire
